// ### logic/ahr_pkg.sv
package ahr_pkg;

  // ==========================================================
  // characters and error codes
  localparam logic [7:0] CH_START     = 8'h3E;
  localparam logic [7:0] CH_CR        = 8'h0D;
  localparam logic [7:0] CH_ACK       = 8'h41;
  localparam logic [7:0] CH_NAK       = 8'h4E;
  localparam logic [7:0] PRINT_LO     = 8'h21;
  localparam logic [7:0] PRINT_HI     = 8'h7F;
  localparam logic [7:0] ERR_PWRUP    = 8'h00;
  localparam logic [7:0] ERR_UNDEF    = 8'h01;
  localparam logic [7:0] ERR_CKSUM    = 8'h02;
  localparam logic [7:0] ERR_OVERRUN  = 8'h03;
  localparam logic [7:0] ERR_NONPRINT = 8'h04;
  localparam logic [7:0] ERR_SHORT    = 8'h05;
  localparam logic [7:0] ERR_WDOG     = 8'h06;

  // ==========================================================
  // sizes
  localparam int          FIFO_DEPTH    = 32;
  localparam int          ANALOG_MAX    = 71;
  localparam int          DIGITAL_MAX   = 16;
  localparam int          MIN_FRAME     = 6;
  localparam int          HDR_LEN       = 4;
  localparam int          CK_LEN        = 2;
  localparam int          ACK_MAX       = 8;
  localparam int          MSG_MAX       = ACK_MAX + 4;
  localparam logic [11:0] ANALOG_FULL   = 12'hFFF;
  localparam logic [15:0] DISCRETE_FULL = 16'hFFFF;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    RX_HUNT    = 2'b00,
    RX_COLLECT = 2'b01,
    RX_EVAL    = 2'b10,
    RX_DRAIN   = 2'b11
  } ahr_rx_state_type;

  typedef enum logic [1:0] {
    RES_OTHER     = 2'b00,
    RES_CKSUM_BAD = 2'b01,
    RES_CMD       = 2'b10,
    RES_NAK       = 2'b11
  } ahr_res_kind_type;

  typedef struct packed {
    ahr_res_kind_type kind;
    logic [7:0]       value;
  } ahr_result_type;

  typedef struct packed {
    logic [3:0]           len;
    logic [ACK_MAX*8-1:0] chars;
  } ahr_ack_type;

  // ==========================================================
  // hex helpers: {valid, nibble}, uppercase only
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39)
      hex_val = {1'b1, c[3:0]};
    else if (c >= 8'h41 && c <= 8'h46)
      hex_val = {1'b1, 4'(c[3:0] + 4'h9)};
    else
      hex_val = 5'h00;
  endfunction : hex_val

  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    hex_chr = (n < 4'hA) ? 8'({4'h0, n} + 8'h30) : 8'({4'h0, n} + 8'h37);
  endfunction : hex_chr

  function automatic logic is_cmd(input logic [7:0] c);
    is_cmd = (c >= 8'h41 && c <= 8'h5A) || (c >= 8'h61 && c <= 8'h7A);
  endfunction : is_cmd

endpackage : ahr_pkg

// ### logic/ahr_responder.sv
`timescale 1ns/1ps

// ==========================================================
// character buffer
module ahr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = ahr_pkg::FIFO_DEPTH
) (
  input  wire logic                       clk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       clr_i,
  input  wire logic                       in_valid_i,
  input  wire logic [WIDTH-1:0]           in_data_i,
  output logic                            in_ready_o,
  output logic                            out_valid_o,
  output logic [WIDTH-1:0]                out_data_o,
  input  wire logic                       out_ready_i,
  output logic [$clog2(DEPTH+1)-1:0]      count_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  // pointers wrap naturally only at a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count < CW'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_idx];
  assign count_o     = count;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[clr_i ? AW'(0) : wr_idx] <= in_data_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end
    else if (clr_i)
    begin
      // a character arriving with the clear survives it
      wr_idx <= AW'(push);
      rd_idx <= '0;
      count  <= CW'(push);
    end
    else
    begin
      if (push)
        wr_idx <= wr_idx + AW'(1);
      if (pop)
        rd_idx <= rd_idx + AW'(1);
      if (push && !pop)
        count <= count + CW'(1);
      else if (pop && !push)
        count <= count - CW'(1);
    end
  end
endmodule : ahr_fifo

// ==========================================================
// framer and responder
module ahr_responder (
  input  wire logic                 clk_i,
  input  wire logic                 rstn_i,
  input  wire logic                 rx_valid_i,
  input  wire logic [7:0]           rx_data_i,
  output logic                      rx_ready_o,
  input  wire logic [7:0]           node_addr_i,
  input  wire logic                 analog_mode_i,
  input  wire logic                 rx_buffer_flush_i,
  output logic                      result_valid_o,
  output ahr_pkg::ahr_result_type   result_o,
  output logic                      pl_valid_o,
  output logic [7:0]                pl_data_o,
  input  wire logic                 pl_ready_i,
  input  wire logic                 ack_req_i,
  input  wire ahr_pkg::ahr_ack_type ack_i,
  input  wire logic                 nak_req_i,
  input  wire logic [7:0]           nak_code_i,
  input  wire logic                 wdog_expire_i,
  output logic                      req_taken_o,
  output logic                      tx_busy_o,
  output logic                      tx_valid_o,
  output logic [7:0]                tx_data_o,
  input  wire logic                 tx_ready_i
);
  localparam int CW = $clog2(ahr_pkg::FIFO_DEPTH+1);

  ahr_pkg::ahr_rx_state_type rx_state;
  ahr_pkg::ahr_rx_state_type next_rx_state;
  logic                      rx_ready;
  logic                      rx_take;
  logic [6:0]                cnt;
  logic [7:0]                sum;
  logic [7:0]                ck_a;
  logic [7:0]                ck_b;
  logic [7:0]                addr;
  logic                      addr_ok;
  logic [7:0]                cmd;
  logic                      bad;
  logic                      ovr;
  logic                      pwr;
  logic [4:0]                hv;
  logic [4:0]                ckh;
  logic [4:0]                ckl;
  logic [6:0]                limit;
  logic [7:0]                body_sum;
  logic                      ck_ok;
  logic                      addr_match;
  logic                      err;
  logic [7:0]                code;
  logic                      eval_fire;
  logic                      eval_nak;
  logic                      fifo_push;
  logic                      fifo_in_ready;
  logic                      fifo_clr;
  logic                      fifo_out_valid;
  logic [7:0]                fifo_out_data;
  logic                      fifo_pop;
  logic [CW-1:0]             fifo_count;
  logic [CW:0]               next_fill;
  logic [6:0]                drain_idx;
  logic                      keep;
  logic                      drain_done;
  logic                      tx_busy;
  logic                      tx_start;
  logic                      wdog_pend;
  logic [7:0]                msg [0:ahr_pkg::MSG_MAX-1];
  logic [7:0]                next_msg [0:ahr_pkg::MSG_MAX-1];
  logic [3:0]                tx_len;
  logic [3:0]                next_len;
  logic [3:0]                tx_idx;

  assign rx_ready_o = rx_ready;
  assign tx_busy_o  = tx_busy;
  assign rx_take    = rx_valid_i && rx_ready;
  assign hv         = ahr_pkg::hex_val(rx_data_i);
  assign limit      = analog_mode_i ? 7'(ahr_pkg::ANALOG_MAX) : 7'(ahr_pkg::DIGITAL_MAX);

  // ==========================================================
  // receive sequencing
  always_comb
  begin
    next_rx_state = rx_state;
    case (rx_state)
      ahr_pkg::RX_HUNT:
        if (rx_take && rx_data_i == ahr_pkg::CH_START)
          next_rx_state = ahr_pkg::RX_COLLECT;
      ahr_pkg::RX_COLLECT:
        if (rx_buffer_flush_i)
          next_rx_state = ahr_pkg::RX_HUNT;
        else if (rx_take && rx_data_i == ahr_pkg::CH_CR)
          next_rx_state = ahr_pkg::RX_EVAL;
      ahr_pkg::RX_EVAL:
        if (eval_fire)
          next_rx_state = (addr_match && !err) ? ahr_pkg::RX_DRAIN : ahr_pkg::RX_HUNT;
      ahr_pkg::RX_DRAIN:
        if (drain_done)
          next_rx_state = ahr_pkg::RX_HUNT;
      default:
        next_rx_state = ahr_pkg::RX_HUNT;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      rx_state <= ahr_pkg::RX_HUNT;
    else
      rx_state <= next_rx_state;
  end

  // characters before '>' are dropped; the carriage return is never stored
  assign fifo_push = fifo_in_ready && rx_take &&
                     ((rx_state == ahr_pkg::RX_HUNT && rx_data_i == ahr_pkg::CH_START) ||
                      (rx_state == ahr_pkg::RX_COLLECT && rx_data_i != ahr_pkg::CH_CR &&
                       !rx_buffer_flush_i));
  assign next_fill = {1'b0, fifo_count} + (CW+1)'(fifo_push);

  // registered ready, so it looks one character ahead
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      rx_ready <= 1'b0;
    else
      rx_ready <= (next_rx_state == ahr_pkg::RX_HUNT || next_rx_state == ahr_pkg::RX_COLLECT)
                  && (next_fill < (CW+1)'(ahr_pkg::FIFO_DEPTH));
  end

  // ==========================================================
  // frame collection
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      cnt     <= 7'h00;
      sum     <= 8'h00;
      ck_a    <= 8'h00;
      ck_b    <= 8'h00;
      addr    <= 8'h00;
      addr_ok <= 1'b0;
      cmd     <= 8'h00;
      bad     <= 1'b0;
      ovr     <= 1'b0;
    end
    else if (fifo_push && rx_state == ahr_pkg::RX_HUNT)
    begin
      cnt     <= 7'h01;
      sum     <= 8'h00;
      addr_ok <= 1'b1;
      bad     <= 1'b0;
      ovr     <= 1'b0;
    end
    else if (fifo_push)
    begin
      if (cnt != 7'h7F)
        cnt <= cnt + 7'h01;
      sum  <= sum + rx_data_i;
      ck_b <= ck_a;
      ck_a <= rx_data_i;
      if (cnt == 7'h01)
      begin
        addr_ok    <= addr_ok & hv[4];
        addr[7:4]  <= hv[3:0];
      end
      if (cnt == 7'h02)
      begin
        addr_ok    <= addr_ok & hv[4];
        addr[3:0]  <= hv[3:0];
      end
      if (cnt == 7'h03)
        cmd <= rx_data_i;
      if (rx_data_i < ahr_pkg::PRINT_LO || rx_data_i > ahr_pkg::PRINT_HI)
        bad <= 1'b1;
      if (cnt >= limit)
        ovr <= 1'b1;
    end
  end

  // ==========================================================
  // evaluation on carriage return
  assign ckh        = ahr_pkg::hex_val(ck_b);
  assign ckl        = ahr_pkg::hex_val(ck_a);
  assign body_sum   = 8'(sum - ck_a - ck_b);
  assign ck_ok      = ckh[4] && ckl[4] && ({ckh[3:0], ckl[3:0]} == body_sum);
  assign addr_match = addr_ok && cnt >= 7'h03 && addr == node_addr_i;
  // waits for a free transmitter so an error reply is never lost
  assign eval_fire  = (rx_state == ahr_pkg::RX_EVAL) && !tx_busy;
  assign eval_nak   = eval_fire && addr_match && err;

  always_comb
  begin
    err  = 1'b1;
    code = ahr_pkg::ERR_PWRUP;
    if (bad)
      code = ahr_pkg::ERR_NONPRINT;
    else if (ovr)
      code = ahr_pkg::ERR_OVERRUN;
    else if (cnt < 7'(ahr_pkg::MIN_FRAME))
      code = ahr_pkg::ERR_SHORT;
    else if (!ck_ok)
      code = ahr_pkg::ERR_CKSUM;
    else if (!ahr_pkg::is_cmd(cmd))
      code = ahr_pkg::ERR_UNDEF;
    else if (pwr && cmd != ahr_pkg::CH_ACK)
      code = ahr_pkg::ERR_PWRUP;
    else
      err = 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      result_valid_o <= 1'b0;
      result_o       <= '{kind: ahr_pkg::RES_OTHER, value: 8'h00};
    end
    else
    begin
      result_valid_o <= eval_fire;
      if (eval_fire && !addr_match)
        result_o <= '{kind: ahr_pkg::RES_OTHER, value: 8'h00};
      else if (eval_fire && err && code == ahr_pkg::ERR_CKSUM)
        result_o <= '{kind: ahr_pkg::RES_CKSUM_BAD, value: code};
      else if (eval_fire && err)
        result_o <= '{kind: ahr_pkg::RES_NAK, value: code};
      else if (eval_fire)
        result_o <= '{kind: ahr_pkg::RES_CMD, value: cmd};
    end
  end

  // the pending state is served by one power-up error reply (code 00), or by an 'A'
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      pwr <= 1'b1;
    else if (eval_fire && addr_match && (!err || code == ahr_pkg::ERR_PWRUP))
      pwr <= 1'b0;
  end

  // ==========================================================
  // buffer and payload drain
  // a bad checksum and a foreign frame leave the buffer for the local logic
  assign fifo_clr = (rx_buffer_flush_i && rx_state != ahr_pkg::RX_DRAIN &&
                     rx_state != ahr_pkg::RX_EVAL) ||
                    (eval_nak && code != ahr_pkg::ERR_CKSUM);

  ahr_fifo #(
    .WIDTH (8),
    .DEPTH (ahr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .clr_i       (fifo_clr),
    .in_valid_i  (fifo_push),
    .in_data_i   (rx_data_i),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_out_data),
    .out_ready_i (fifo_pop),
    .count_o     (fifo_count)
  );

  assign fifo_pop   = (rx_state == ahr_pkg::RX_DRAIN) && fifo_out_valid &&
                      (!pl_valid_o || pl_ready_i);
  assign keep       = drain_idx >= 7'(ahr_pkg::HDR_LEN) &&
                      drain_idx < 7'(cnt - 7'(ahr_pkg::CK_LEN));
  assign drain_done = fifo_pop && drain_idx == 7'(cnt - 7'h01);

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || eval_fire)
      drain_idx <= 7'h00;
    else if (fifo_pop)
      drain_idx <= drain_idx + 7'h01;
  end

  // payload characters go out unchanged, still ASCII-hex
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      pl_valid_o <= 1'b0;
      pl_data_o  <= 8'h00;
    end
    else if (fifo_pop && keep)
    begin
      pl_valid_o <= 1'b1;
      pl_data_o  <= fifo_out_data;
    end
    else if (pl_ready_i)
      pl_valid_o <= 1'b0;
  end

  // ==========================================================
  // reply builder
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      wdog_pend <= 1'b0;
    else if (wdog_expire_i)
      wdog_pend <= 1'b1;
    else if (tx_start && !eval_nak)
      wdog_pend <= 1'b0;
  end

  assign tx_start = !tx_busy && (eval_nak || wdog_pend || nak_req_i || ack_req_i);

  always_comb
  begin
    logic [3:0] alen;
    logic [7:0] csum;
    logic [7:0] ncode;
    alen  = (ack_i.len > 4'(ahr_pkg::ACK_MAX)) ? 4'(ahr_pkg::ACK_MAX) : ack_i.len;
    csum  = 8'h00;
    ncode = eval_nak ? code : (wdog_pend ? ahr_pkg::ERR_WDOG : nak_code_i);
    for (int i = 0; i < ahr_pkg::MSG_MAX; i++)
      next_msg[i] = 8'h00;
    if (eval_nak || wdog_pend || nak_req_i)
    begin
      next_msg[0] = ahr_pkg::CH_NAK;
      next_msg[1] = ahr_pkg::hex_chr(ncode[7:4]);
      next_msg[2] = ahr_pkg::hex_chr(ncode[3:0]);
      next_msg[3] = ahr_pkg::CH_CR;
      next_len    = 4'h4;
    end
    else
    begin
      next_msg[0] = ahr_pkg::CH_ACK;
      for (int i = 0; i < ahr_pkg::ACK_MAX; i++)
        if (4'(i) < alen)
        begin
          next_msg[i+1] = ack_i.chars[8*i +: 8];
          csum          = csum + ack_i.chars[8*i +: 8];
        end
      if (alen == 4'h0)
      begin
        next_msg[1] = ahr_pkg::CH_CR;
        next_len    = 4'h2;
      end
      else
      begin
        next_msg[alen+4'h1] = ahr_pkg::hex_chr(csum[7:4]);
        next_msg[alen+4'h2] = ahr_pkg::hex_chr(csum[3:0]);
        next_msg[alen+4'h3] = ahr_pkg::CH_CR;
        next_len            = alen + 4'h4;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      req_taken_o <= 1'b0;
    else
      req_taken_o <= tx_start && !eval_nak && !wdog_pend;
  end

  // ==========================================================
  // transmit sequencing
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      tx_busy    <= 1'b0;
      tx_valid_o <= 1'b0;
      tx_data_o  <= 8'h00;
      tx_len     <= 4'h0;
      tx_idx     <= 4'h0;
    end
    else if (tx_start)
    begin
      msg     <= next_msg;
      tx_len  <= next_len;
      tx_idx  <= 4'h0;
      tx_busy <= 1'b1;
    end
    else if (tx_busy && (!tx_valid_o || tx_ready_i))
    begin
      if (tx_idx < tx_len)
      begin
        tx_data_o  <= msg[tx_idx];
        tx_valid_o <= 1'b1;
        tx_idx     <= tx_idx + 4'h1;
      end
      else
      begin
        tx_valid_o <= 1'b0;
        tx_busy    <= 1'b0;
      end
    end
  end
endmodule : ahr_responder

// ### tb/ahr_sva.sv
`timescale 1ns/1ps
// ==========================================
// result and reply port checks
module ahr_checker (
  input wire logic                    clk_i,
  input wire logic                    rstn_i,
  input wire logic                    result_valid_o,
  input wire ahr_pkg::ahr_result_type result_o,
  input wire logic                    pl_valid_o,
  input wire logic [7:0]              pl_data_o,
  input wire logic                    pl_ready_i,
  input wire logic                    req_taken_o,
  input wire logic                    tx_busy_o,
  input wire logic                    tx_valid_o,
  input wire logic [7:0]              tx_data_o,
  input wire logic                    tx_ready_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_foreign_zero: assert property (
    result_valid_o && result_o.kind == ahr_pkg::RES_OTHER |-> result_o.value == 8'h00)
    else $error("foreign address result not zero");
  a_cksum_negative: assert property (
    result_valid_o && result_o.kind == ahr_pkg::RES_CKSUM_BAD |-> result_o.value == 8'h02)
    else $error("checksum result value wrong");
  a_cmd_letter: assert property (
    result_valid_o && result_o.kind == ahr_pkg::RES_CMD
    |-> result_o.value inside {[8'h41:8'h5A], [8'h61:8'h7A]})
    else $error("non letter reported as command");
  a_reply_lead: assert property (
    $rose(tx_busy_o) |=> tx_valid_o && (tx_data_o == 8'h41 || tx_data_o == 8'h4E))
    else $error("reply does not open with A or N");
  a_taken_busy: assert property (
    req_taken_o |-> tx_busy_o)
    else $error("request taken without busy");
  a_idle_quiet: assert property (
    !tx_busy_o |-> !tx_valid_o)
    else $error("reply character while idle");
  a_tx_hold: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("reply character dropped while stalled");
  a_pl_hold: assert property (
    pl_valid_o && !pl_ready_i |=> pl_valid_o && $stable(pl_data_o))
    else $error("payload character dropped while stalled");
  a_pl_after_cmd: assert property (
    $rose(pl_valid_o) |-> ##[0:2] result_o.kind == ahr_pkg::RES_CMD)
    else $error("payload without good frame");
endmodule : ahr_checker

// ### tb/ahr_host.sv
`timescale 1ns/1ps
// ==========================================
// polling host: feeds frame characters, collects replies
module ahr_host (
  input  wire logic       clk_i,
  input  wire logic       rx_ready_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  logic [7:0] txq[$];
  logic [7:0] got[$];
  integer     seed = 32'hDDFE;
  initial
  begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
    tx_ready_o = 1'b0;
  end
  task automatic put(input string s);
    foreach (s[i])
      txq.push_back(s[i]);
  endtask : put
  always @(posedge clk_i)
  begin
    // random stalls exercise the hold side of the reply port
    tx_ready_o <= ($random(seed) & 3) != 0;
    if (tx_valid_i && tx_ready_o)
      got.push_back(tx_data_i);
    if (!rx_valid_o || rx_ready_i)
    begin
      rx_valid_o <= txq.size() > 0;
      // released line toggles so a stale character is never reused
      rx_data_o  <= (txq.size() > 0) ? txq.pop_front() : ~rx_data_o;
    end
  end
endmodule : ahr_host

// ### tb/ascii_hex_node_responder_bench.sv
`timescale 1ns/1ps
module ascii_hex_node_responder_bench;
  // ==========================================
  // signals
  logic                    clk_i = 1'b0;
  logic                    rstn_i = 1'b0;
  logic                    rx_buffer_flush_i = 1'b0;
  logic                    pl_ready_i = 1'b0;
  logic                    ack_req_i = 1'b0;
  logic                    nak_req_i = 1'b0;
  logic                    wdog_expire_i = 1'b0;
  logic                    analog_mode_i = 1'b0;
  logic [7:0]              node_addr_i = 8'h05;
  logic [7:0]              nak_code_i = 8'h00;
  ahr_pkg::ahr_ack_type    ack_i = '0;
  ahr_pkg::ahr_result_type result_o;
  logic                    rx_valid_i, rx_ready_o, result_valid_o, pl_valid_o;
  logic                    req_taken_o, tx_busy_o, tx_valid_o, tx_ready_i;
  logic [7:0]              rx_data_i, pl_data_o, tx_data_o;
  logic [9:0]              res_q[$];
  logic [7:0]              pl_q[$];
  integer                  seed = 32'hDDFE;
  integer                  error_cnt = 0;
  integer                  checked = 0;

  ahr_responder DUT (.clk_i, .rstn_i, .rx_valid_i, .rx_data_i, .rx_ready_o, .node_addr_i,
    .analog_mode_i, .rx_buffer_flush_i, .result_valid_o, .result_o, .pl_valid_o, .pl_data_o,
    .pl_ready_i, .ack_req_i, .ack_i, .nak_req_i, .nak_code_i, .wdog_expire_i, .req_taken_o,
    .tx_busy_o, .tx_valid_o, .tx_data_o, .tx_ready_i);
  ahr_host u_host (.clk_i, .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i),
    .rx_data_o(rx_data_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
    .tx_ready_o(tx_ready_i));

  initial
  begin
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    pl_ready_i <= ($random(seed) & 3) != 0;
    if (result_valid_o === 1'b1)
      res_q.push_back(result_o);
    if (pl_valid_o && pl_ready_i)
      pl_q.push_back(pl_data_o);
  end

  // ==========================================
  // model helpers
  function automatic string hx(input logic [3:0] n);
    string r = "0";
    r[0] = (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
    return r;
  endfunction : hx
  function automatic string frm(input logic [7:0] a, input string b, input logic [7:0] ckx);
    string      s;
    logic [7:0] ck = 8'h00;
    s = {hx(a[7:4]), hx(a[3:0]), b};
    foreach (s[i])
      ck += s[i];
    ck ^= ckx;
    return {">", s, hx(ck[7:4]), hx(ck[3:0]), "\r"};
  endfunction : frm
  function automatic logic [79:0] pk(input string s);
    logic [79:0] v = '0;
    foreach (s[i])
      v = {v[71:0], s[i]};
    return v;
  endfunction : pk
  function automatic logic [79:0] qpk(input logic [7:0] q[$]);
    logic [79:0] v = '0;
    foreach (q[i])
      v = {v[71:0], q[i]};
    return v;
  endfunction : qpk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] s);
    checked++;
    if (e !== s)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // quiet for 16 cycles means the exchange is over; a header drain alone is 6
  task automatic settle;
    int n = 0;
    int q = 0;
    while (q < 16)
    begin
      @(posedge clk_i);
      n++;
      q = (!tx_busy_o && !pl_valid_o && !rx_valid_i && u_host.txq.size() == 0) ? q + 1 : 0;
      if (n > 800)
      begin
        error_cnt++;
        print_verdict();
      end
    end
  endtask : settle
  task automatic frame_case(input string nm, input string f, input logic [9:0] er,
                            input string etx, input string epl, input bit fl);
    res_q.delete();
    pl_q.delete();
    u_host.got.delete();
    u_host.put(f);
    settle();
    chk("result", {54'h0, er}, {54'h0, (res_q.size() == 1) ? res_q[0] : 10'hX});
    chk("reply", pk(etx), qpk(u_host.got));
    chk("payload", pk(epl), qpk(pl_q));
    chk("payload_count", epl.len(), pl_q.size());
    if (fl)
    begin
      rx_buffer_flush_i <= 1'b1;
      @(posedge clk_i);
      rx_buffer_flush_i <= 1'b0;
      @(posedge clk_i);
    end
    $display("done %s", nm);
  endtask : frame_case
  task automatic reply_case(input string nm, input logic [2:0] rq,
                            input ahr_pkg::ahr_ack_type ak, input logic [7:0] cd,
                            input string etx);
    int n = 0;
    u_host.got.delete();
    ack_req_i     <= rq[0];
    nak_req_i     <= rq[1];
    wdog_expire_i <= rq[2];
    ack_i         <= ak;
    nak_code_i    <= cd;
    @(posedge clk_i);
    wdog_expire_i <= 1'b0;
    while (!rq[2] && req_taken_o !== 1'b1 && n < 100)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 100)
    begin
      error_cnt++;
      print_verdict();
    end
    ack_req_i <= 1'b0;
    nak_req_i <= 1'b0;
    settle();
    chk("reply", pk(etx), qpk(u_host.got));
    $display("done %s", nm);
  endtask : reply_case

  // ==========================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    frame_case("pwrup", frm(8'h05, "J12", 8'h00), {2'h3, 8'h00}, "N00\r", "", 0);
    frame_case("good", frm(8'h05, "J12", 8'h00), {2'h2, 8'h4A}, "", "12", 0);
    frame_case("foreign", frm(8'h07, "J12", 8'h00), {2'h0, 8'h00}, "", "", 1);
    frame_case("cksum", frm(8'h05, "J12", 8'h01), {2'h1, 8'h02}, "N02\r", "", 1);
    frame_case("refill", frm(8'h05, "J34", 8'h00), {2'h2, 8'h4A}, "", "34", 0);
    frame_case("undef", frm(8'h05, "112", 8'h00), {2'h3, 8'h01}, "N01\r", "", 0);
    frame_case("nonprint", frm(8'h05, "J\020", 8'h00), {2'h3, 8'h04}, "N04\r", "", 0);
    frame_case("over", frm(8'h05, "J1234567890A", 8'h00), {2'h3, 8'h03}, "N03\r", "", 0);
    frame_case("max", frm(8'h05, "J1234567890", 8'h00), {2'h2, 8'h4A}, "", "1234567890", 0);
    frame_case("short", ">05A\r", {2'h3, 8'h05}, "N05\r", "", 0);
    analog_mode_i <= 1'b1;
    frame_case("ana", frm(8'h05, "J1234567890A", 8'h00), {2'h2, 8'h4A}, "",
               "1234567890A", 0);
    reply_case("ack_data", 3'h1, '{4'h2, 64'h3231}, 8'h00, "A1263\r");
    reply_case("ack_empty", 3'h1, '{4'h0, 64'h0}, 8'h00, "A\r");
    reply_case("nak", 3'h2, '{4'h0, 64'h0}, 8'hA7, "NA7\r");
    reply_case("wdog", 3'h4, '{4'h0, 64'h0}, 8'h00, "N06\r");
    print_verdict();
  end
endmodule : ascii_hex_node_responder_bench

bind ahr_responder ahr_checker u_chk (.clk_i, .rstn_i, .result_valid_o, .result_o,
  .pl_valid_o, .pl_data_o, .pl_ready_i, .req_taken_o, .tx_busy_o, .tx_valid_o, .tx_data_o,
  .tx_ready_i);
